// ### src/wp_status_pkg.sv
// shared constants for the write-protect and status logic
package wp_status_pkg;
    localparam int ADDR_W = 20;
    localparam int REG_ADDR_W = 24;
    localparam int PROT_BASE_SHIFT = 13;
    localparam int BP_W = 3;
    localparam logic [2:0] BP_NONE = 3'h0;
    localparam logic [2:0] BP_FULL = 3'h7;
    localparam int SR1_LOCK_BIT = 7;
    localparam int SR1_TB_BIT = 5;
    localparam int SR1_BP_HI = 4;
    localparam int SR1_BP_LO = 2;
    localparam int SR1_WEL_BIT = 1;
    localparam int SR1_BUSY_BIT = 0;
    localparam logic [7:0] SR1_WR_MASK = 8'hBC;
    localparam logic [7:0] SR1_RESET = 8'h00;
    localparam int SR2_SUSP_BIT = 4;
    localparam int SR2_ABORT_BIT = 3;
    localparam logic [7:0] SR2_ZERO = 8'h00;
    localparam logic [23:0] SR1_NV_ADDR = 24'h000000;
    localparam logic [23:0] SR1_V_ADDR = 24'h070000;
    localparam logic [23:0] SR2_NV_ADDR = 24'h000001;
    localparam logic [23:0] SR2_V_ADDR = 24'h070001;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_SPECIAL_SECTOR_WRITE = 8'h42;
    localparam logic [7:0] OP_ANY_REGISTER_WRITE = 8'h71;
    localparam logic [7:0] OP_SERIAL_NUMBER_WRITE = 8'hC2;
    localparam logic [ADDR_W:0] CRC_MIN_SPAN = 21'h000003;
endpackage : wp_status_pkg

// ### src/sticky_flag.sv
// one volatile flag: set wins over clear, reset wins over both
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
    input wire logic clk,
    input wire logic rst,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end
endmodule : sticky_flag
`default_nettype wire

// ### src/protect_range.sv
// decodes block-protect code and anchor into an address hit
`timescale 1ns/1ps
`default_nettype none
module protect_range #(
    parameter int AW = wp_status_pkg::ADDR_W
) (
    input wire logic [2:0] bp,
    input wire logic bottom,
    input wire logic [AW-1:0] addr,
    output logic hit
);
    import wp_status_pkg::*;
    if (AW < PROT_BASE_SHIFT + 7) begin : g_width_check
        $error("protect_range: address too narrow for the codes");
    end
    // each step doubles the range: code 1 is 2^(base+1) bytes
    logic [AW-1:0] low_mask;
    logic [AW-1:0] keep_mask;
    logic all_ones;
    logic all_zero;
    assign low_mask = (AW'(1) << (PROT_BASE_SHIFT + int'(bp))) - AW'(1);
    assign keep_mask = ~low_mask;
    assign all_ones = ((addr & keep_mask) == keep_mask);
    assign all_zero = ((addr & keep_mask) == '0);
    assign hit = (bp == BP_NONE) ? 1'b0 :
                 (bp == BP_FULL) ? 1'b1 :
                 bottom ? all_zero : all_ones;
endmodule : protect_range
`default_nettype wire

// ### src/wp_status_logic.sv
// write-protect gating, latch, busy and crc status flags
// Notes on behaviour
// - status one: anchor b5, code b4:2, latch b1, busy b0
// - anchor bit picks top or bottom range
// - top anchor: codes grow range ending at top
// - bottom anchor: codes grow range starting at zero
// - writes inside protected range always refused
// - no write of any kind without latch
// - only write enable command sets latch
// - listed opcodes clear latch at command end
// - memory writes leave latch set
// - latch reads zero after every reset
// - lock bit and low pin block registers
// - read-only and reserved bits never written
// - busy high only while crc runs
// - while busy only status reads, any register read, suspend, reset
// - busy is volatile, cleared by every reset
// - status two readable by command or address
// - status two reserved bits read zero
// - suspend during crc sets suspended flag
// - resume command clears suspended flag
// - span under one word aborts and flags
// - successful crc start clears aborted flag
// - resets clear suspended and aborted flags
// - lock bit zero gives no register protection
`timescale 1ns/1ps
`default_nettype none
module wp_status_logic #(
    parameter int AW = wp_status_pkg::ADDR_W,
    parameter logic [7:0] OP_WRITE_ENABLE = 8'h06,
    parameter logic [7:0] OP_STATUS1_READ = 8'h05,
    parameter logic [7:0] OP_STATUS2_READ = 8'h07,
    parameter logic [7:0] OP_ANY_REGISTER_READ = 8'h65,
    parameter logic [7:0] OP_CRC_SUSPEND = 8'hB0,
    parameter logic [7:0] OP_CRC_RESUME = 8'h30,
    parameter logic [7:0] OP_RESET_ARM = 8'h66,
    parameter logic [7:0] OP_RESET_GO = 8'h99
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic HW_RST,
    input wire logic [7:0] NV_SR1,
    input wire logic WP_N,
    input wire logic CMD_START,
    input wire logic [7:0] CMD_OPCODE,
    input wire logic CMD_END,
    output logic CMD_ACCEPT,
    input wire logic MEM_WR_REQ,
    input wire logic [AW-1:0] MEM_WR_ADDR,
    output logic MEM_WR_OK,
    input wire logic REG_WR_REQ,
    input wire logic [wp_status_pkg::REG_ADDR_W-1:0] REG_WR_ADDR,
    input wire logic [7:0] REG_WR_DATA,
    output logic REG_WR_OK,
    input wire logic RD_REQ,
    input wire logic [wp_status_pkg::REG_ADDR_W-1:0] RD_ADDR,
    output logic [7:0] RD_DATA,
    output logic RD_HIT,
    input wire logic CRC_REQ,
    input wire logic [AW-1:0] CRC_START_ADDR,
    input wire logic [AW-1:0] CRC_END_ADDR,
    input wire logic CRC_DONE,
    output logic CRC_RUN,
    output logic SOFT_RESET,
    output logic [7:0] STATUS_ONE,
    output logic [7:0] STATUS_TWO
);
    import wp_status_pkg::*;

    // range decode assumes the full array map
    if (AW != ADDR_W) begin : g_width_check
        $error("wp_status_logic: array address width must match the map");
    end

    // command tracking
    logic [7:0] cur_op;
    logic cur_ok;
    logic in_cmd;
    logic end_ok;
    logic [7:0] sr1_cfg;
    logic write_enable_latch;
    logic busy_flag;
    logic crc_suspended_flag;
    logic crc_aborted_flag;
    logic reset_armed;
    logic soft_rst;
    logic reset_any;

    assign end_ok = CMD_END & in_cmd & cur_ok;

    // decode of the opcode being taken now
    logic status1_read_cmd;
    logic status2_read_cmd;
    logic any_register_read_cmd;
    logic opc_crc_suspend;
    logic opc_reset_arm;
    logic opc_reset_go;
    assign status1_read_cmd = (CMD_OPCODE == OP_STATUS1_READ);
    assign status2_read_cmd = (CMD_OPCODE == OP_STATUS2_READ);
    assign any_register_read_cmd = (CMD_OPCODE == OP_ANY_REGISTER_READ);
    assign opc_crc_suspend = (CMD_OPCODE == OP_CRC_SUSPEND);
    assign opc_reset_arm = (CMD_OPCODE == OP_RESET_ARM);
    assign opc_reset_go = (CMD_OPCODE == OP_RESET_GO);

    logic op_busy_safe;
    assign op_busy_safe = status1_read_cmd |
                          status2_read_cmd |
                          any_register_read_cmd |
                          opc_crc_suspend |
                          opc_reset_arm |
                          opc_reset_go;
    assign CMD_ACCEPT = ~busy_flag | op_busy_safe;

    always_ff @(posedge MCLK) begin
        if (SYS_RST | HW_RST | soft_rst) begin
            cur_op <= 8'h00;
            cur_ok <= 1'b0;
            in_cmd <= 1'b0;
        end else if (CMD_START) begin
            cur_op <= CMD_OPCODE;
            cur_ok <= CMD_ACCEPT;
            in_cmd <= 1'b1;
        end else if (CMD_END) begin
            in_cmd <= 1'b0;
        end
    end

    // decode of the held opcode, acted on at command end
    logic write_enable_cmd;
    logic write_disable_cmd;
    logic status_write_cmd;
    logic special_sector_write_cmd;
    logic any_register_write_cmd;
    logic serial_number_write_cmd;
    logic crc_suspend_cmd;
    logic crc_resume_cmd;
    logic reset_arm_cmd;
    logic reset_go_cmd;
    assign write_enable_cmd = (cur_op == OP_WRITE_ENABLE);
    assign write_disable_cmd = (cur_op == OP_WRITE_DISABLE);
    assign status_write_cmd = (cur_op == OP_STATUS_WRITE);
    assign special_sector_write_cmd = (cur_op == OP_SPECIAL_SECTOR_WRITE);
    assign any_register_write_cmd = (cur_op == OP_ANY_REGISTER_WRITE);
    assign serial_number_write_cmd = (cur_op == OP_SERIAL_NUMBER_WRITE);
    assign crc_suspend_cmd = (cur_op == OP_CRC_SUSPEND);
    assign crc_resume_cmd = (cur_op == OP_CRC_RESUME);
    assign reset_arm_cmd = (cur_op == OP_RESET_ARM);
    assign reset_go_cmd = (cur_op == OP_RESET_GO);

    // software reset is a two-command sequence
    logic arm_set;
    logic arm_clr;
    assign arm_set = end_ok & reset_arm_cmd;
    assign arm_clr = end_ok & ~reset_arm_cmd;
    assign soft_rst = end_ok & reset_go_cmd & reset_armed;
    // every reset kind clears the volatile flags
    assign reset_any = SYS_RST | HW_RST | soft_rst;

    sticky_flag u_arm (
        .clk(MCLK),
        .rst(reset_any),
        .set(arm_set),
        .clr(arm_clr),
        .q(reset_armed)
    );

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            SOFT_RESET <= 1'b0;
        end else begin
            SOFT_RESET <= soft_rst;
        end
    end

    // only write enable sets the latch
    logic wel_set;
    logic wel_clr;
    assign wel_set = end_ok & write_enable_cmd;
    // listed opcodes only; memory writes absent
    assign wel_clr = end_ok & (write_disable_cmd |
                               status_write_cmd |
                               special_sector_write_cmd |
                               any_register_write_cmd |
                               serial_number_write_cmd);

    sticky_flag u_wel (
        .clk(MCLK),
        .rst(reset_any),
        .set(wel_set),
        .clr(wel_clr),
        .q(write_enable_latch)
    );

    // protection configuration fields
    logic register_lock_bit;
    logic top_bottom_select;
    logic [2:0] block_protect;
    logic block_protect_hi;
    logic block_protect_mid;
    logic block_protect_lo;
    assign register_lock_bit = sr1_cfg[SR1_LOCK_BIT];
    assign top_bottom_select = sr1_cfg[SR1_TB_BIT];
    assign block_protect = sr1_cfg[SR1_BP_HI:SR1_BP_LO];
    assign block_protect_hi = block_protect[2];
    assign block_protect_mid = block_protect[1];
    assign block_protect_lo = block_protect[0];

    logic prot_hit;
    protect_range #(
        .AW(AW)
    ) u_range (
        .bp({block_protect_hi, block_protect_mid, block_protect_lo}),
        .bottom(top_bottom_select),
        .addr(MEM_WR_ADDR),
        .hit(prot_hit)
    );

    // array write gate; ignored while busy
    assign MEM_WR_OK = MEM_WR_REQ & write_enable_latch & ~prot_hit & ~busy_flag;

    // register write gate
    logic sr1_target;
    logic sr2_target;
    logic reg_locked;
    assign sr1_target = (REG_WR_ADDR == SR1_NV_ADDR) | (REG_WR_ADDR == SR1_V_ADDR);
    assign sr2_target = (REG_WR_ADDR == SR2_NV_ADDR) | (REG_WR_ADDR == SR2_V_ADDR);
    // lock needs both bit and low pin
    assign reg_locked = register_lock_bit & ~WP_N;
    assign REG_WR_OK = REG_WR_REQ & write_enable_latch & ~reg_locked &
                       ~busy_flag & ~sr2_target;

    logic [7:0] sr1_wr_value;
    assign sr1_wr_value = REG_WR_DATA & SR1_WR_MASK;

    // hardware reset reloads the non-volatile copy, system reset zeroes it; soft reset keeps it
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            sr1_cfg <= SR1_RESET;
        end else if (HW_RST) begin
            sr1_cfg <= NV_SR1 & SR1_WR_MASK;
        end else if (REG_WR_OK & sr1_target) begin
            sr1_cfg <= sr1_wr_value;
        end
    end

    // crc start check, span computed one bit wider
    logic [AW:0] span_limit;
    logic crc_try;
    logic crc_bad;
    logic crc_good;
    assign span_limit = {1'b0, CRC_START_ADDR} + CRC_MIN_SPAN;
    assign crc_try = CRC_REQ & ~busy_flag & ~crc_suspended_flag;
    // end below start plus three aborts
    assign crc_bad = crc_try & ({1'b0, CRC_END_ADDR} < span_limit);
    assign crc_good = crc_try & ~crc_bad;

    // suspend and resume
    logic susp_go;
    logic resume_go;
    assign susp_go = end_ok & crc_suspend_cmd & busy_flag;
    assign resume_go = end_ok & crc_resume_cmd & crc_suspended_flag;

    sticky_flag u_susp (
        .clk(MCLK),
        .rst(reset_any),
        .set(susp_go),
        .clr(resume_go),
        .q(crc_suspended_flag)
    );

    sticky_flag u_abort (
        .clk(MCLK),
        .rst(reset_any),
        .set(crc_bad),
        .clr(crc_good),
        .q(crc_aborted_flag)
    );

    // busy only while the engine runs
    always_ff @(posedge MCLK) begin
        if (reset_any) begin
            busy_flag <= 1'b0;
        end else if (crc_good | resume_go) begin
            busy_flag <= 1'b1;
        end else if (CRC_DONE | susp_go) begin
            busy_flag <= 1'b0;
        end
    end
    assign CRC_RUN = busy_flag;

    logic [7:0] status_reg_one;
    assign status_reg_one = {register_lock_bit, 1'b0, top_bottom_select,
                             block_protect_hi, block_protect_mid, block_protect_lo,
                             write_enable_latch, busy_flag};
    // reserved bits of status two stay zero
    logic [7:0] status_reg_two;
    always_comb begin
        status_reg_two = SR2_ZERO;
        status_reg_two[SR2_SUSP_BIT] = crc_suspended_flag;
        status_reg_two[SR2_ABORT_BIT] = crc_aborted_flag;
    end
    assign STATUS_ONE = status_reg_one;
    assign STATUS_TWO = status_reg_two;

    // read selection; config registers live outside
    logic rd_sr1;
    logic rd_sr2;
    logic cmd_sr1;
    logic cmd_sr2;
    logic [7:0] next_rd_data;
    logic next_rd_hit;
    assign cmd_sr1 = CMD_START & CMD_ACCEPT & status1_read_cmd;
    assign cmd_sr2 = CMD_START & CMD_ACCEPT & status2_read_cmd;
    assign rd_sr1 = RD_REQ & ((RD_ADDR == SR1_NV_ADDR) | (RD_ADDR == SR1_V_ADDR));
    assign rd_sr2 = RD_REQ & ((RD_ADDR == SR2_NV_ADDR) | (RD_ADDR == SR2_V_ADDR));
    assign next_rd_hit = cmd_sr1 | cmd_sr2 | rd_sr1 | rd_sr2;
    assign next_rd_data = (cmd_sr1 | rd_sr1) ? status_reg_one :
                          (cmd_sr2 | rd_sr2) ? status_reg_two : RD_DATA;

    // data held until the next hit, so a slow shifter can take it
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            RD_DATA <= 8'h00;
            RD_HIT <= 1'b0;
        end else begin
            RD_DATA <= next_rd_data;
            RD_HIT <= next_rd_hit;
        end
    end
endmodule : wp_status_logic
`default_nettype wire

// ### dv/wp_status_chk.sv
// checker for the write-protect and status logic ports
`timescale 1ns/1ps
`default_nettype none
module wp_status_chk #(
    parameter int AW = wp_status_pkg::ADDR_W
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic HW_RST,
    input wire logic WP_N,
    input wire logic CMD_START,
    input wire logic [7:0] CMD_OPCODE,
    input wire logic CMD_END,
    input wire logic CMD_ACCEPT,
    input wire logic MEM_WR_REQ,
    input wire logic MEM_WR_OK,
    input wire logic REG_WR_REQ,
    input wire logic REG_WR_OK,
    input wire logic CRC_REQ,
    input wire logic [AW-1:0] CRC_START_ADDR,
    input wire logic [AW-1:0] CRC_END_ADDR,
    input wire logic CRC_RUN,
    input wire logic [7:0] STATUS_ONE,
    input wire logic [7:0] STATUS_TWO
);
    import wp_status_pkg::*;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);
    property p_busy_bit; STATUS_ONE[SR1_BUSY_BIT] == CRC_RUN; endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit differs from run");
    property p_sr2_rsvd; (STATUS_TWO & 8'hE7) == 8'h00; endproperty
    a_sr2_rsvd: assert property (p_sr2_rsvd) else $error("status two reserved set");
    property p_mem_gate;
        MEM_WR_REQ && MEM_WR_OK |-> STATUS_ONE[1] && !CRC_RUN && STATUS_ONE[4:2] != BP_FULL;
    endproperty
    a_mem_gate: assert property (p_mem_gate) else $error("array write wrongly allowed");
    property p_reg_lock;
        REG_WR_REQ && (!STATUS_ONE[1] || (STATUS_ONE[7] && !WP_N)) |-> !REG_WR_OK;
    endproperty
    a_reg_lock: assert property (p_reg_lock) else $error("register write not locked");
    property p_wel_rise; $rose(STATUS_ONE[1]) |-> $past(CMD_END); endproperty
    a_wel_rise: assert property (p_wel_rise) else $error("latch set outside command");
    property p_busy_rise; $rose(CRC_RUN) |-> $past(CRC_REQ) || $past(CMD_END); endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy raised without cause");
    property p_hw_clear; HW_RST |=> STATUS_ONE[1:0] == 2'b00 && STATUS_TWO == 8'h00; endproperty
    a_hw_clear: assert property (p_hw_clear) else $error("flags kept over reset");
    property p_abort;
        CRC_REQ && !CRC_RUN && !STATUS_TWO[4]
            && {1'b0, CRC_END_ADDR} < {1'b0, CRC_START_ADDR} + CRC_MIN_SPAN
            |=> STATUS_TWO[3] && !CRC_RUN;
    endproperty
    a_abort: assert property (p_abort) else $error("short span not aborted");
    property p_busy_refuse;
        CMD_START && CRC_RUN && !(CMD_OPCODE inside {8'h05, 8'h07, 8'h65, 8'hB0, 8'h66, 8'h99})
            |-> !CMD_ACCEPT;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("command taken while busy");
endmodule : wp_status_chk
bind wp_status_logic wp_status_chk #(.AW(AW)) i_wp_status_chk (.MCLK, .SYS_RST, .HW_RST,
    .WP_N, .CMD_START, .CMD_OPCODE, .CMD_END, .CMD_ACCEPT, .MEM_WR_REQ, .MEM_WR_OK,
    .REG_WR_REQ, .REG_WR_OK, .CRC_REQ, .CRC_START_ADDR, .CRC_END_ADDR, .CRC_RUN,
    .STATUS_ONE, .STATUS_TWO);
`default_nettype wire

// ### dv/host_model.sv
// host-side command driver standing in for the serial controller
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic MCLK,
    input wire logic CMD_ACCEPT,
    output logic CMD_START,
    output logic [7:0] CMD_OPCODE,
    output logic CMD_END
);
    logic acc;
    initial begin
        CMD_START = 1'b0;
        CMD_OPCODE = 8'h00;
        CMD_END = 1'b0;
    end
    // readiness by timing, busy never polled
    task automatic cmd(input logic [7:0] op, input int gap);
        @(posedge MCLK) #2;
        CMD_START = 1'b1;
        CMD_OPCODE = op;
        #10 acc = CMD_ACCEPT;
        @(posedge MCLK) #2;
        CMD_START = 1'b0;
        // released bus shows inverse, stale opcode never matches
        CMD_OPCODE = ~op;
        repeat (gap) begin
            @(posedge MCLK) #2;
        end
        CMD_END = 1'b1;
        @(posedge MCLK) #2;
        CMD_END = 1'b0;
    endtask : cmd
endmodule : host_model
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the write-protect and status logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import wp_status_pkg::*;
    logic MCLK, SYS_RST, HW_RST, WP_N, MEM_WR_REQ, REG_WR_REQ, RD_REQ, CRC_REQ, CRC_DONE;
    logic CMD_START, CMD_END, CMD_ACCEPT, MEM_WR_OK, REG_WR_OK, RD_HIT, CRC_RUN, SOFT_RESET;
    logic [7:0] NV_SR1, REG_WR_DATA, RD_DATA, STATUS_ONE, STATUS_TWO, CMD_OPCODE;
    logic [19:0] MEM_WR_ADDR, CRC_START_ADDR, CRC_END_ADDR;
    logic [23:0] REG_WR_ADDR, RD_ADDR;
    int errors = 0;
    int checks_done = 0;
    wp_status_logic i_wp_status_logic (.MCLK, .SYS_RST, .HW_RST, .NV_SR1, .WP_N, .CMD_START,
        .CMD_OPCODE, .CMD_END, .CMD_ACCEPT, .MEM_WR_REQ, .MEM_WR_ADDR, .MEM_WR_OK, .REG_WR_REQ,
        .REG_WR_ADDR, .REG_WR_DATA, .REG_WR_OK, .RD_REQ, .RD_ADDR, .RD_DATA, .RD_HIT, .CRC_REQ,
        .CRC_START_ADDR, .CRC_END_ADDR, .CRC_DONE, .CRC_RUN, .SOFT_RESET, .STATUS_ONE,
        .STATUS_TWO);
    host_model i_host_model (.MCLK, .CMD_ACCEPT, .CMD_START, .CMD_OPCODE, .CMD_END);
    initial begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end
    task automatic report_and_stop;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic tick;
        @(posedge MCLK) #2;
    endtask : tick
    task automatic mem_wr(input logic [19:0] a, input logic exp);
        tick();
        MEM_WR_ADDR = a;
        MEM_WR_REQ = 1'b1;
        #10 chk(MEM_WR_OK, exp, "array write");
        tick();
        MEM_WR_REQ = 1'b0;
    endtask : mem_wr
    task automatic reg_wr(input logic [23:0] a, input logic [7:0] d, input logic exp);
        tick();
        REG_WR_ADDR = a;
        REG_WR_DATA = d;
        REG_WR_REQ = 1'b1;
        #10 chk(REG_WR_OK, exp, "register write");
        tick();
        REG_WR_REQ = 1'b0;
    endtask : reg_wr
    task automatic rd(input logic [23:0] a, input logic [7:0] exp);
        tick();
        RD_ADDR = a;
        RD_REQ = 1'b1;
        tick();
        RD_REQ = 1'b0;
        chk(RD_HIT, 1'b1, "read hit");
        chk(RD_DATA, exp, "read data");
    endtask : rd
    task automatic crc(input logic [19:0] sa, input logic [19:0] ea);
        tick();
        CRC_START_ADDR = sa;
        CRC_END_ADDR = ea;
        CRC_REQ = 1'b1;
        tick();
        CRC_REQ = 1'b0;
    endtask : crc
    task automatic t_latch;
        logic [7:0] clr_ops [5] = '{8'h04, 8'h01, 8'h42, 8'h71, 8'hC2};
        chk(STATUS_ONE, 8'h00, "status one at start");
        chk(STATUS_TWO, 8'h00, "status two at start");
        mem_wr(20'h00000, 1'b0);
        foreach (clr_ops[i]) begin
            i_host_model.cmd(8'h06, 2);
            chk(STATUS_ONE, 8'h02, "latch set");
            mem_wr(20'hFFFFF, 1'b1);
            i_host_model.cmd(8'h02, 0);
            chk(STATUS_ONE[1], 1'b1, "latch kept");
            i_host_model.cmd(clr_ops[i], 1);
            chk(STATUS_ONE[1], 1'b0, "latch cleared");
        end
        i_host_model.cmd(8'h05, 0);
        chk(STATUS_ONE[1], 1'b0, "latch stays low");
    endtask : t_latch
    task automatic t_range;
        logic [20:0] sz;
        logic [19:0] lo;
        logic [19:0] hi;
        i_host_model.cmd(8'h06, 0);
        for (int tb = 0; tb < 2; tb++) begin
            for (int bp = 0; bp < 8; bp++) begin
                reg_wr(24'h070000, {2'b01, tb[0], bp[2:0], 2'b11}, 1'b1);
                chk(STATUS_ONE, {2'b00, tb[0], bp[2:0], 2'b10}, "fields");
                sz = (bp == 0) ? 21'h0 : (bp == 7) ? 21'h100000 : 21'h1 << (13 + bp);
                lo = (tb == 1) ? 20'h0 : 20'(21'h100000 - sz);
                hi = (tb == 1) ? 20'(sz - 21'h1) : 20'hFFFFF;
                if (bp == 0) mem_wr(tb ? 20'h0 : 20'hFFFFF, 1'b1);
                else mem_wr(tb ? hi : lo, 1'b0);
                if (bp inside {[1:6]}) mem_wr(tb ? hi + 20'h1 : lo - 20'h1, 1'b1);
            end
        end
    endtask : t_range
    task automatic t_lock;
        reg_wr(24'h070000, 8'h80, 1'b1);
        WP_N = 1'b0;
        reg_wr(24'h070000, 8'h00, 1'b0);
        chk(STATUS_ONE, 8'h82, "refused write");
        mem_wr(20'h12345, 1'b1);
        WP_N = 1'b1;
        reg_wr(24'h070001, 8'h18, 1'b0);
        reg_wr(24'h070000, 8'h00, 1'b1);
        i_host_model.cmd(8'h04, 0);
        reg_wr(24'h070000, 8'h1C, 1'b0);
        chk(STATUS_ONE, 8'h00, "unlatched write");
    endtask : t_lock
    task automatic t_crc;
        crc(20'h00010, 20'h00012);
        chk(STATUS_TWO, 8'h08, "aborted");
        chk(CRC_RUN, 1'b0, "not running");
        crc(20'h00010, 20'h00013);
        chk(STATUS_TWO, 8'h00, "abort cleared");
        chk(STATUS_ONE[0], 1'b1, "busy");
        i_host_model.cmd(8'h06, 0);
        chk(i_host_model.acc, 1'b0, "ignored");
        chk(STATUS_ONE[1], 1'b0, "latch untouched");
        i_host_model.cmd(8'h05, 0);
        chk(i_host_model.acc, 1'b1, "status read");
        chk(RD_DATA, 8'h01, "status one by command");
        i_host_model.cmd(8'h65, 0);
        chk(i_host_model.acc, 1'b1, "register read");
        i_host_model.cmd(8'hB0, 0);
        chk(STATUS_TWO, 8'h10, "suspended");
        i_host_model.cmd(8'h07, 0);
        chk(RD_DATA, 8'h10, "status two by command");
        rd(24'h000001, 8'h10);
        rd(24'h070001, 8'h10);
        i_host_model.cmd(8'h30, 0);
        chk(STATUS_TWO, 8'h00, "resumed");
        chk(CRC_RUN, 1'b1, "running again");
        CRC_DONE = 1'b1;
        tick();
        CRC_DONE = 1'b0;
        chk(CRC_RUN, 1'b0, "finished");
    endtask : t_crc
    task automatic t_reset;
        crc(20'h00000, 20'h00003);
        i_host_model.cmd(8'hB0, 0);
        i_host_model.cmd(8'h66, 0);
        i_host_model.cmd(8'h99, 0);
        chk(SOFT_RESET, 1'b1, "soft reset pulse");
        chk(STATUS_TWO, 8'h00, "soft reset");
        crc(20'h00010, 20'h00011);
        i_host_model.cmd(8'h06, 0);
        NV_SR1 = 8'hFF;
        HW_RST = 1'b1;
        tick();
        HW_RST = 1'b0;
        chk(STATUS_TWO, 8'h00, "hard reset");
        chk(STATUS_ONE, 8'hBC, "hard reset load");
        crc(20'h00000, 20'h00004);
        SYS_RST = 1'b1;
        tick();
        SYS_RST = 1'b0;
        chk(STATUS_ONE, 8'h00, "power reset");
    endtask : t_reset
    initial begin
        SYS_RST = 1'b1;
        {HW_RST, WP_N, MEM_WR_REQ, REG_WR_REQ, RD_REQ, CRC_REQ, CRC_DONE} = 7'b0100000;
        {NV_SR1, REG_WR_DATA, MEM_WR_ADDR, REG_WR_ADDR, RD_ADDR, CRC_START_ADDR} = '0;
        CRC_END_ADDR = 20'h00000;
        repeat (4) @(posedge MCLK);
        #2 SYS_RST = 1'b0;
        t_latch();
        t_range();
        t_lock();
        t_crc();
        t_reset();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
